//--- hdl/pmt_pkg.sv
/*
  Shared constants for the 8-bit period-match timer: register offsets,
  field positions, reset values and divider figures.
  Assumes a 100 MHz pclk standing in for the oscillator and an APB bus.
*/
`default_nettype none
package pmt_pkg;
  // ---------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] CNT_OFF  = 8'h04;
  localparam logic [ADDR_W-1:0] PER_OFF  = 8'h08;
  localparam logic [ADDR_W-1:0] FLAG_OFF = 8'h0c;
  localparam logic [ADDR_W-1:0] EN_OFF   = 8'h10;

  // ---------------------------------------------------------------
  // Fields of timer_control and the flag registers
  // ---------------------------------------------------------------
  localparam int unsigned PRE_LSB   = 0;
  localparam int unsigned PRE_MSB   = 1;
  localparam int unsigned ON_BIT    = 2;
  localparam int unsigned POST_LSB  = 3;
  localparam int unsigned POST_MSB  = 6;
  localparam int unsigned CTRL_W    = 7;
  localparam int unsigned FLAG_BIT  = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [7:0]        CNT_RST  = 8'h00;
  localparam logic [7:0]        PER_RST  = 8'hff;

  // ---------------------------------------------------------------
  // Dividers
  // ---------------------------------------------------------------
  localparam int unsigned OSC_PERIOD_NS = 10;
  localparam int unsigned ICLK_NS       = 40;
  localparam int unsigned ICLK_CYCLES   = ICLK_NS / OSC_PERIOD_NS;
  localparam logic [1:0]  ICLK_LAST     = 2'(ICLK_CYCLES - 1);
  localparam logic [1:0]  PRE_SEL_DIV1  = 2'h0;
  localparam logic [1:0]  PRE_SEL_DIV4  = 2'h1;
  localparam logic [3:0]  PRE1_LAST     = 4'h0;
  localparam logic [3:0]  PRE4_LAST     = 4'h3;
  localparam logic [3:0]  PRE16_LAST    = 4'hf;
endpackage : pmt_pkg
`default_nettype wire

//--- hdl/pmt_scale_if.sv
/*
  Carrier between the timer core and its prescaler.
  Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface pmt_scale_if;
  logic       clr;
  logic       run;
  logic [1:0] sel;
  logic       tick;
  logic [3:0] pre_count;
  modport core   (output clr, output run, output sel,
                  input tick, input pre_count);
  modport scaler (input clr, input run, input sel,
                  output tick, output pre_count);
endinterface : pmt_scale_if
`default_nettype wire

//--- hdl/pmt_prescaler.sv
/*
  Instruction clock divider and selectable prescaler of the timer.
  Assumes clr and run come from logic on the same pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pmt_prescaler (
  input wire logic    pclk,
  input wire logic    presetn,
  pmt_scale_if.scaler sc
);
  import pmt_pkg::*;

  logic [1:0] iclk_cnt_ff;
  logic [3:0] pre_cnt_ff;
  logic [3:0] pre_last;
  logic       iclk_tick;

  // ---------------------------------------------------------------
  // Instruction clock: free running, never cleared by writes
  // ---------------------------------------------------------------
  assign iclk_tick = (iclk_cnt_ff == ICLK_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iclk_cnt_ff <= 2'h0;
    end else begin
      iclk_cnt_ff <= iclk_cnt_ff + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  always_comb begin
    case (sc.sel)
      PRE_SEL_DIV1: pre_last = PRE1_LAST;
      PRE_SEL_DIV4: pre_last = PRE4_LAST;
      default:      pre_last = PRE16_LAST;
    endcase
  end

  // Halted while off so a stopped timer's prescaler draws no toggling; the instruction clock keeps running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_ff <= 4'h0;
    end else if (sc.clr) begin
      pre_cnt_ff <= 4'h0;
    end else if (sc.run && iclk_tick) begin
      pre_cnt_ff <= (pre_cnt_ff == pre_last) ? 4'h0 : pre_cnt_ff + 4'h1;
    end
  end

  assign sc.tick      = sc.run && iclk_tick && !sc.clr &&
                        (pre_cnt_ff == pre_last);
  assign sc.pre_count = pre_cnt_ff;
endmodule : pmt_prescaler
`default_nettype wire

//--- hdl/pmt_timer.sv
/*
  8-bit period-match timer with prescaler, postscaler, match flag
  and interrupt, reached over APB.
  Assumes an APB3 master on pclk; serial port and PWM logic sit on
  the same clock.
*/
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pmt_timer (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pmt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [pmt_pkg::DATA_W-1:0] pwdata,
  output logic      [pmt_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq,
  output logic                            shift_clk_src,
  output logic      [7:0]                 pwm_count,
  output logic                            pwm_match
);
  import pmt_pkg::*;

  logic [DATA_W-1:0] prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic [CTRL_W-1:0] ctrl_ff;
  logic [7:0]        counter_ff;
  logic [7:0]        period_ff;
  logic [3:0]        post_cnt_ff;
  logic              flag_ff;
  logic              enable_ff;
  logic              irq_ff;
  logic              shift_ff;
  logic              pwm_match_ff;
  logic [DATA_W-1:0] nxt_prdata;
  logic              nxt_slverr;
  logic              acc_first;
  logic              wr_en;
  logic              wr_ctrl;
  logic              wr_cnt;
  logic              wr_per;
  logic              wr_flag;
  logic              wr_en_reg;
  logic              match;
  logic              post_fire;
  logic [3:0]        post_sel;
  logic              timer_on;

  pmt_scale_if sc_if ();

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // One wait state: data is fetched in the first access cycle and
  // pready rises in the second, so reads see a settled register.
  assign acc_first = psel && penable && !pready_ff;
  assign wr_en     = psel && penable && pready_ff && pwrite;
  assign wr_ctrl   = wr_en && (paddr == CTRL_OFF);
  assign wr_cnt    = wr_en && (paddr == CNT_OFF);
  assign wr_per    = wr_en && (paddr == PER_OFF);
  assign wr_flag   = wr_en && (paddr == FLAG_OFF);
  assign wr_en_reg = wr_en && (paddr == EN_OFF);

  always_comb begin
    nxt_prdata = '0;
    nxt_slverr = 1'b0;
    case (paddr)
      CTRL_OFF: nxt_prdata[CTRL_W-1:0] = ctrl_ff;
      CNT_OFF:  nxt_prdata[7:0] = counter_ff;
      PER_OFF:  nxt_prdata[7:0] = period_ff;
      FLAG_OFF: nxt_prdata[FLAG_BIT] = flag_ff;
      EN_OFF:   nxt_prdata[FLAG_BIT] = enable_ff;
      default:  nxt_slverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= acc_first;
      prdata_ff  <= acc_first && !pwrite ? nxt_prdata : '0;
      pslverr_ff <= acc_first && nxt_slverr;
    end
  end

  // ---------------------------------------------------------------
  // Control and period registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_ff <= PER_RST;
    end else if (wr_per) begin
      period_ff <= pwdata[7:0];
    end
  end

  assign timer_on = ctrl_ff[ON_BIT];
  assign post_sel = ctrl_ff[POST_MSB:POST_LSB];

  assign sc_if.clr = wr_ctrl || wr_cnt;
  assign sc_if.run = timer_on;
  assign sc_if.sel = ctrl_ff[PRE_MSB:PRE_LSB];

  pmt_prescaler u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .sc      (sc_if.scaler)
  );

  // ---------------------------------------------------------------
  // Counter and period match
  // ---------------------------------------------------------------
  // Tick is already suppressed by the scaler clear, so a control
  // write cannot move the count.
  assign match = sc_if.tick && (counter_ff == period_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_ff <= CNT_RST;
    end else if (wr_cnt) begin
      counter_ff <= pwdata[7:0];
    end else if (match) begin
      counter_ff <= CNT_RST;
    end else if (sc_if.tick) begin
      counter_ff <= counter_ff + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Postscaler, flag and interrupt
  // ---------------------------------------------------------------
  assign post_fire = match && (post_cnt_ff == post_sel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt_ff <= 4'h0;
    end else if (sc_if.clr) begin
      post_cnt_ff <= 4'h0;
    end else if (post_fire) begin
      post_cnt_ff <= 4'h0;
    end else if (match) begin
      post_cnt_ff <= post_cnt_ff + 4'h1;
    end
  end

  // Set beats a same-cycle write-one clear so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else if (post_fire) begin
      flag_ff <= 1'b1;
    end else if (wr_flag && pwdata[FLAG_BIT]) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= 1'b0;
    end else if (wr_en_reg) begin
      enable_ff <= pwdata[FLAG_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && enable_ff;
    end
  end

  // ---------------------------------------------------------------
  // Serial port and PWM feeds
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ff     <= 1'b0;
      pwm_match_ff <= 1'b0;
    end else begin
      shift_ff     <= match;
      pwm_match_ff <= match;
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign irq           = irq_ff;
  assign shift_clk_src = shift_ff;
  assign pwm_count     = counter_ff;
  assign pwm_match     = pwm_match_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [7:0] gap_ff;
  logic       gap_ok_ff;
  logic [3:0] mcnt_ff;
  logic       mok_ff;
  logic [7:0] gap_need;

  assign gap_need = 8'(ICLK_CYCLES * (32'(sc_if.sel == PRE_SEL_DIV1 ? 1 :
                    sc_if.sel == PRE_SEL_DIV4 ? 4 : 16))) - 8'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff    <= 8'h00;
      gap_ok_ff <= 1'b0;
    end else begin
      gap_ff    <= sc_if.tick ? 8'h00 : gap_ff + 8'h01;
      gap_ok_ff <= sc_if.tick || (gap_ok_ff && !sc_if.clr && timer_on);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcnt_ff <= 4'h0;
      mok_ff  <= 1'b0;
    end else begin
      if (post_fire) begin
        mcnt_ff <= 4'h0;
      end else if (match) begin
        mcnt_ff <= mcnt_ff + 4'h1;
      end
      mok_ff <= post_fire || (mok_ff && !sc_if.clr);
    end
  end

  sequence s_cnt_write;
    wr_cnt;
  endsequence
  sequence s_quiet_tick;
    sc_if.tick && !wr_cnt;
  endsequence

  property p_wrap;
    s_quiet_tick and (counter_ff == period_ff) |=> counter_ff == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at period");

  property p_step;
    s_quiet_tick and (counter_ff != period_ff)
      |=> counter_ff == $past(counter_ff) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("counter missed a step");

  property p_pre_gap;
    sc_if.tick && gap_ok_ff |-> gap_ff == gap_need;
  endproperty
  a_pre_gap: assert property (p_pre_gap) else $error("bad tick gap");

  property p_post;
    post_fire && mok_ff |-> mcnt_ff == post_sel;
  endproperty
  a_post: assert property (p_post) else $error("bad postscale");

  property p_flag;
    post_fire |=> flag_ff ##1 (flag_ff || $past(wr_flag));
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");

  // A write of one clears the flag unless a new event lands with it
  property p_flag_clr;
    wr_flag && pwdata[FLAG_BIT] && !post_fire |=> !flag_ff;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag kept");

  property p_clr;
    sc_if.clr |=> sc_if.pre_count == 4'h0 && post_cnt_ff == 4'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("scalers not cleared");

  property p_ctrl_keep;
    wr_ctrl |=> $stable(counter_ff);
  endproperty
  a_ctrl_keep: assert property (p_ctrl_keep) else $error("count moved");

  property p_cnt_wr;
    s_cnt_write |=> counter_ff == $past(pwdata[7:0]);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost");

  property p_per_wr;
    wr_per |=> period_ff == $past(pwdata[7:0]);
  endproperty
  a_per_wr: assert property (p_per_wr) else $error("period write lost");

  property p_off;
    !timer_on && !wr_cnt |=> $stable(counter_ff);
  endproperty
  a_off: assert property (p_off) else $error("stopped timer moved");

  property p_feed;
    match |=> shift_clk_src && pwm_match;
  endproperty
  a_feed: assert property (p_feed) else $error("match not fed out");

  property p_irq;
    flag_ff && enable_ff |=> irq ##1 (irq || !$past(flag_ff && enable_ff));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_no_irq;
    !(flag_ff && enable_ff) |=> !irq;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("spurious irq");

  property p_bit7;
    pready && paddr == CTRL_OFF && !pwrite |-> prdata[7] == 1'b0;
  endproperty
  a_bit7: assert property (p_bit7) else $error("control bit 7 set");
endmodule : pmt_timer
`default_nettype wire

//--- dv/pmt_far_model.sv
/*
  Far-side model: serial port and PWM logic that watch the timer's
  match pulse and live count. Assumes the same pclk as the timer.
*/
`timescale 1ns/1ps
`default_nettype none
module pmt_far_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        shift_clk_src,
  input  wire logic        pwm_match,
  input  wire logic [7:0]  pwm_count,
  input  wire logic        clr_cnt,
  output logic      [15:0] n_pulse_ff,
  output logic      [15:0] gap_ff,
  output logic      [7:0]  max_cnt_ff,
  output logic             pair_ok_ff
);
  // ---------------------------------------------------------------
  // Shift clock source: pulse count and spacing
  // ---------------------------------------------------------------
  logic [15:0] run_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_pulse_ff <= 16'h0000;
      run_ff     <= 16'h0000;
      gap_ff     <= 16'h0000;
    end else if (clr_cnt) begin
      n_pulse_ff <= 16'h0000;
      run_ff     <= 16'h0000;
    end else if (shift_clk_src) begin
      n_pulse_ff <= n_pulse_ff + 16'h0001;
      gap_ff     <= run_ff;
      run_ff     <= 16'h0001;
    end else begin
      run_ff <= run_ff + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // PWM time base: highest count seen, match tied to shift source
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_cnt_ff <= 8'h00;
      pair_ok_ff <= 1'b1;
    end else if (clr_cnt) begin
      max_cnt_ff <= 8'h00;
    end else begin
      if (pwm_count > max_cnt_ff) max_cnt_ff <= pwm_count;
      if (pwm_match !== shift_clk_src) pair_ok_ff <= 1'b0;
    end
  end
endmodule : pmt_far_model
`default_nettype wire

//--- dv/pmt_timer_test.sv
/*
  Self-checking bench of the period-match timer over APB.
  Assumes the hand-over timing: one wait state, tick every 4 pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module pmt_timer_test;
  import pmt_pkg::*;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              shift_clk_src;
  logic [7:0]        pwm_count;
  logic              pwm_match;
  logic              clr_cnt = 1'b0;
  logic [15:0]       n_pulse;
  logic [15:0]       gap;
  logic [7:0]        max_cnt;
  logic              pair_ok;
  logic [31:0]       rd;
  logic              err;
  int                n_errors = 0;
  int                n_tests = 0;
  int                dv [4] = '{1, 4, 16, 16};
  always #5 pclk = ~pclk;
  pmt_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .shift_clk_src(shift_clk_src), .pwm_count(pwm_count),
    .pwm_match(pwm_match));
  pmt_far_model u_far (.pclk(pclk), .presetn(presetn),
    .shift_clk_src(shift_clk_src), .pwm_match(pwm_match),
    .pwm_count(pwm_count), .clr_cnt(clr_cnt), .n_pulse_ff(n_pulse),
    .gap_ff(gap), .max_cnt_ff(max_cnt), .pair_ok_ff(pair_ok));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Read data and error are taken at the edge that sees pready
  task automatic apb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= we; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin n_errors++; end_of_test(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc

  // Bounded wait for n match pulses seen by the far side
  task automatic wait_pulses(input int n);
    int i;
    for (i = 0; i < 2000 && n_pulse < 16'(n); i++) @(posedge pclk);
    if (i == 2000) begin n_errors++; end_of_test(); end
  endtask : wait_pulses

  task automatic clr_far();
    @(posedge pclk); clr_cnt <= 1'b1;
    @(posedge pclk); clr_cnt <= 1'b0;
  endtask : clr_far

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(CTRL_OFF, 32'h0);
    rchk(CNT_OFF, 32'h0);
    rchk(PER_OFF, 32'hff);
    rchk(FLAG_OFF, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, 8'h14, 32'h5a);
    `CHK(err, 1'b1)
    done("reset");
    apb(1'b1, CTRL_OFF, 32'hff);
    rchk(CTRL_OFF, 32'h7f);
    apb(1'b1, CTRL_OFF, 32'h00);
    apb(1'b1, PER_OFF, 32'h5a);
    rchk(PER_OFF, 32'h5a);
    apb(1'b1, CNT_OFF, 32'h20);
    wait_cyc(100);
    rchk(CNT_OFF, 32'h20);
    apb(1'b1, CTRL_OFF, 32'h78);
    rchk(CNT_OFF, 32'h20);
    done("access");
    // Writes closer than one div-16 tick must keep the count frozen
    apb(1'b1, PER_OFF, 32'hff);
    apb(1'b1, CTRL_OFF, 32'h06);
    for (i = 0; i < 6; i++) begin
      apb(1'b1, CNT_OFF, 32'h10);
      wait_cyc(50);
      rchk(CNT_OFF, 32'h10);
    end
    apb(1'b1, CNT_OFF, 32'h10);
    for (i = 0; i < 6; i++) begin
      apb(1'b1, CTRL_OFF, 32'h06);
      wait_cyc(50);
    end
    rchk(CNT_OFF, 32'h10);
    done("scaler_clear");
    apb(1'b1, PER_OFF, 32'h3);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, CTRL_OFF, 32'h0);
      apb(1'b1, CNT_OFF, 32'h0);
      clr_far();
      apb(1'b1, CTRL_OFF, 32'h4 | i);
      wait_pulses(3);
      `CHK(gap, 16'(4 * 4 * dv[i]))
      `CHK(max_cnt, 8'h03)
    end
    `CHK(pair_ok, 1'b1)
    done("prescale");
    apb(1'b1, CTRL_OFF, 32'h0);
    apb(1'b1, CNT_OFF, 32'h0);
    apb(1'b1, PER_OFF, 32'h7);
    apb(1'b1, FLAG_OFF, 32'h2);
    apb(1'b1, EN_OFF, 32'h2);
    clr_far();
    apb(1'b1, CTRL_OFF, 32'h14);
    for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge pclk);
    if (i == 400) begin n_errors++; end_of_test(); end
    wait_cyc(2);
    `CHK(n_pulse, 16'h3)
    apb(1'b1, EN_OFF, 32'h0);
    wait_cyc(2);
    `CHK(irq, 1'b0)
    apb(1'b1, CTRL_OFF, 32'h0);
    rchk(FLAG_OFF, 32'h2);
    apb(1'b1, EN_OFF, 32'h2);
    wait_cyc(2);
    `CHK(irq, 1'b1)
    apb(1'b1, FLAG_OFF, 32'h2);
    rchk(FLAG_OFF, 32'h0);
    `CHK(irq, 1'b0)
    done("interrupt");
    // Reset in mid-run, with the timer counting and the period moved
    apb(1'b1, PER_OFF, 32'h3);
    apb(1'b1, CTRL_OFF, 32'h7e);
    wait_cyc(300);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(pwm_count, 8'h00)
    rchk(CTRL_OFF, 32'h0);
    rchk(CNT_OFF, 32'h0);
    rchk(PER_OFF, 32'hff);
    `CHK(irq, 1'b0)
    done("midrun_reset");
    end_of_test();
  end
endmodule : pmt_timer_test
`default_nettype wire
